//--- src/pieb_top.v
// port input enable bank: registers for port A bit 0 and ports B, C, D
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
`include "pieb_defs.vh"
// How it works
// - Port B enable register sits at 0x30B9, eight read/write bits, bit n for pin n.
// - A port B enable bit at 0 blocks that pin's input and at 1 passes it.
// - Port C enable register sits at 0x30BA, eight read/write bits, bit n for pin n.
// - A port C enable bit at 0 blocks that pin's input and at 1 passes it.
// - Port D enable register sits at 0x30BB, eight read/write bits, bit n for pin n.
// - A port D enable bit at 0 blocks that pin's input and at 1 passes it.
// - Port A bit 0 enable is read/write and blocks at 0, passes at 1.
module pieb_top
(
	// clock and reset
	input  wire                     clock_i,
	input  wire                     reset_i,
	// register port
	input  wire [`PIEB_ADDR_W-1:0]  addr_i,
	input  wire [`PIEB_DATA_W-1:0]  wdata_i,
	input  wire                     wr_i,
	input  wire                     rd_i,
	output reg  [`PIEB_DATA_W-1:0]  rdata_o,
	// pins
	input  wire                     porta_pin_i,
	input  wire [7:0]               portb_pin_i,
	input  wire [7:0]               portc_pin_i,
	input  wire [7:0]               portd_pin_i,
	// gated inputs
	output wire                     porta_in_o,
	output wire [7:0]               portb_in_o,
	output wire [7:0]               portc_in_o,
	output wire [7:0]               portd_in_o,
	// enables as stored
	output reg                      porta_in_gate_0,
	output reg  [7:0]               portb_in_gate_r,
	output reg  [7:0]               portc_in_gate_r,
	output reg  [7:0]               portd_in_gate_r
);
	reg [`PIEB_DATA_W-1:0] rdata_nxt;

	always @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			porta_in_gate_0 <= `PIEB_RST_PORTA;
			portb_in_gate_r <= `PIEB_RST_PORTB;
			portc_in_gate_r <= `PIEB_RST_PORTC;
			portd_in_gate_r <= `PIEB_RST_PORTD;
		end
		else if (wr_i)
		begin
			case (addr_i)
				`PIEB_OFF_PORTA: porta_in_gate_0 <= wdata_i[`PIEB_PORTA_BIT];
				`PIEB_OFF_PORTB: portb_in_gate_r <= wdata_i;
				`PIEB_OFF_PORTC: portc_in_gate_r <= wdata_i;
				`PIEB_OFF_PORTD: portd_in_gate_r <= wdata_i;
				default:         porta_in_gate_0 <= porta_in_gate_0;
			endcase
		end
	end

	// read mux; unmapped and port A upper bits read zero
	always @*
	begin
		rdata_nxt = {`PIEB_DATA_W{1'b0}};
		case (addr_i)
			`PIEB_OFF_PORTA: rdata_nxt[`PIEB_PORTA_BIT] = porta_in_gate_0;
			`PIEB_OFF_PORTB: rdata_nxt = portb_in_gate_r;
			`PIEB_OFF_PORTC: rdata_nxt = portc_in_gate_r;
			`PIEB_OFF_PORTD: rdata_nxt = portd_in_gate_r;
			default:         rdata_nxt = {`PIEB_DATA_W{1'b0}};
		endcase
	end

	always @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
			rdata_o <= {`PIEB_DATA_W{1'b0}};
		else if (rd_i)
			rdata_o <= rdata_nxt;
		else
			rdata_o <= {`PIEB_DATA_W{1'b0}};
	end

	pieb_gate #(.WIDTH(1)) u_gate_a
	(
		.clock_i  (clock_i),
		.reset_i  (reset_i),
		.enable_i (porta_in_gate_0),
		.pin_i    (porta_pin_i),
		.data_o   (porta_in_o)
	);

	pieb_gate #(.WIDTH(8)) u_gate_b
	(
		.clock_i  (clock_i),
		.reset_i  (reset_i),
		.enable_i (portb_in_gate_r),
		.pin_i    (portb_pin_i),
		.data_o   (portb_in_o)
	);

	pieb_gate #(.WIDTH(8)) u_gate_c
	(
		.clock_i  (clock_i),
		.reset_i  (reset_i),
		.enable_i (portc_in_gate_r),
		.pin_i    (portc_pin_i),
		.data_o   (portc_in_o)
	);

	pieb_gate #(.WIDTH(8)) u_gate_d
	(
		.clock_i  (clock_i),
		.reset_i  (reset_i),
		.enable_i (portd_in_gate_r),
		.pin_i    (portd_pin_i),
		.data_o   (portd_in_o)
	);
endmodule

//--- src/pieb_defs.vh
// register offsets, widths and reset values of the port input enable bank
`ifndef PIEB_DEFS_VH
`define PIEB_DEFS_VH
`define PIEB_ADDR_W       16
`define PIEB_DATA_W       8
`define PIEB_OFF_PORTA    16'h30B8
`define PIEB_OFF_PORTB    16'h30B9
`define PIEB_OFF_PORTC    16'h30BA
`define PIEB_OFF_PORTD    16'h30BB
`define PIEB_RST_PORTA    1'h0
`define PIEB_RST_PORTB    8'h00
`define PIEB_RST_PORTC    8'h00
`define PIEB_RST_PORTD    8'h00
`define PIEB_PORTA_BIT    0
`endif

//--- src/pieb_gate.v
// one port's WIDTH input gates (eight for ports B, C, D, one for port A): pin sync and enable masking
`timescale 1ns/10ps
module pieb_gate
#(
	parameter WIDTH = 8
)
(
	// clock and reset
	input  wire             clock_i,
	input  wire             reset_i,
	// enables and pins
	input  wire [WIDTH-1:0] enable_i,
	input  wire [WIDTH-1:0] pin_i,
	// gated input
	output reg  [WIDTH-1:0] data_o
);
	reg [WIDTH-1:0] sync1_r;
	reg [WIDTH-1:0] sync2_r;

	always @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			sync1_r <= {WIDTH{1'b0}};
			sync2_r <= {WIDTH{1'b0}};
			data_o  <= {WIDTH{1'b0}};
		end
		else
		begin
			sync1_r <= pin_i;
			sync2_r <= sync1_r;
			// disabled path reads as zero
			data_o  <= sync2_r & enable_i;
		end
	end
endmodule

//--- tb/pieb_props.sv
// property checker of the port input enable bank
`timescale 1ns/10ps
module pieb_props(input wire clock_i,reset_i,wr_i,porta_in_gate_0,input wire [15:0] addr_i,
	input wire [7:0] wdata_i,portb_in_gate_r,portc_in_gate_r,portd_in_gate_r,portb_in_o,portc_in_o,portd_in_o);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	b_store_a: assert property (wr_i&&addr_i==16'h30B9 |=> portb_in_gate_r==$past(wdata_i)) else $error("b store");
	c_store_a: assert property (wr_i&&addr_i==16'h30BA |=> portc_in_gate_r==$past(wdata_i)) else $error("c store");
	d_store_a: assert property (wr_i&&addr_i==16'h30BB |=> portd_in_gate_r==$past(wdata_i)) else $error("d store");
	a_store_a: assert property (wr_i&&addr_i==16'h30B8 |=> porta_in_gate_0==$past(wdata_i[0])) else $error("a store");
	b_mask_a: assert property (!(|(portb_in_o&~portb_in_gate_r&~$past(portb_in_gate_r)))) else $error("b mask");
	c_mask_a: assert property (!(|(portc_in_o&~portc_in_gate_r&~$past(portc_in_gate_r)))) else $error("c mask");
	d_mask_a: assert property (!(|(portd_in_o&~portd_in_gate_r&~$past(portd_in_gate_r)))) else $error("d mask");
	b_reset_a: assert property ($fell(reset_i) |-> portb_in_gate_r==8'h00) else $error("b reset");
endmodule
bind pieb_top pieb_props chk_u(.*);

//--- tb/tb_top.sv
// self-checking bench of the port input enable bank
`timescale 1ns/10ps
module tb_top;
	reg clock_i=0,reset_i=1,wr_i=0,rd_i=0,porta_pin_i=1;
	reg [15:0] addr_i=0;
	reg [7:0] wdata_i=0,portb_pin_i=8'hFF,portc_pin_i=8'hFF,portd_pin_i=8'hFF;
	wire porta_in_o,porta_in_gate_0;
	wire [7:0] rdata_o,portb_in_o,portc_in_o,portd_in_o,portb_in_gate_r,portc_in_gate_r,portd_in_gate_r;
	integer num_errors=0,total_checks=0,cyc=0;
	always #2.5 clock_i=~clock_i;
	pieb_top dut_u(.*);
	task chk(input [7:0] g,e);
	begin
		total_checks=total_checks+1;
		if(g!==e)
		begin
			num_errors=num_errors+1;
			$display("ERROR t=%0t got %h exp %h",$time,g,e);
		end
	end
	endtask
	task wrrd(input [15:0] a,input [7:0] d,e);
	begin
		@(posedge clock_i) {addr_i,wdata_i,wr_i}<={a,d,1'b1};
		@(posedge clock_i) {wr_i,rd_i}<=2'b01;
		@(posedge clock_i) rd_i<=0;
		#1 chk(rdata_o,e);
		@(posedge clock_i) #1 chk(rdata_o,8'h00);
	end
	endtask
	task end_of_test;
	begin
		$display("errors %0d checks %0d",num_errors,total_checks);
		if(num_errors==0&&total_checks>0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	end
	endtask
	always @(posedge clock_i)
	begin
		cyc<=cyc+1;
		if(cyc==2000)
		begin
			num_errors=num_errors+1;
			end_of_test;
		end
	end
	initial
	begin
		repeat(12) @(posedge clock_i);
		reset_i<=0;
		#1 chk(portb_in_gate_r,8'h00);
		wrrd(16'h30B9,8'hA5,8'hA5);
		wrrd(16'h30BA,8'h3C,8'h3C);
		wrrd(16'h30BB,8'h81,8'h81);
		wrrd(16'h30B8,8'hFF,8'h01);
		wrrd(16'h30C0,8'h77,8'h00);
		repeat(4) @(posedge clock_i);
		#1 chk(portb_in_o,8'hA5);
		chk(portc_in_o,8'h3C);
		chk(portd_in_o,8'h81);
		chk({7'h00,porta_in_o},8'h01);
		reset_i=1;
		#1 chk(portb_in_gate_r,8'h00);
		@(posedge clock_i) reset_i<=0;
		end_of_test;
	end
endmodule
